// *** core/ldoreg_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
module ldoreg_bank
  import ldoreg_pkg::*;
#(
  parameter int unsigned NUM_LDO = 6,
  parameter logic [NUM_LDO*8-1:0] OTP_CTRL_DEFAULT = '0,
  parameter logic [5:0] OTP_CEIL_DEFAULT = 6'h3f
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic otp_reload_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rd_hit_o,
  input wire logic [NUM_LDO-1:0] forced_off_i,
  output logic [NUM_LDO-1:0] ldo_en_o,
  output logic [NUM_LDO-1:0] ldo_lowpwr_o,
  output logic [NUM_LDO*SEL_W-1:0] ldo_sel_o,
  output logic ceil_locked_o
);

  ////////////////////////////////////////////////////////////////////////
  // The decoder and the read mux are written out for six channels, so a
  // different count is refused while the design elaborates.
  if (NUM_LDO != 6) begin : g_bad_count
    $error("ldoreg_bank serves exactly six regulators");
  end

  ////////////////////////////////////////////////////////////////////////
  // Stored register contents and the ceiling and clamp logic built on them
  logic [7:0] ctrl [NUM_LDO];
  logic [5:0] ceil;
  logic [5:0] next_ceil;
  logic ceil_lock;
  logic ceil_open;
  logic ceil_wr_ok;
  logic [5:0] clamped;

  // Decoder outputs and read path
  logic [NUM_LDO-1:0] hit;
  logic ceil_hit;
  logic [DATA_W-1:0] next_rdata;
  logic next_rd_hit;

  ////////////////////////////////////////////////////////////////////////
  // Address decode: one select per register, never more than one high.
  // Offsets outside the bank leave every select low, so such writes are
  // dropped and such reads return zero.
  always_comb begin
    hit = '0;
    ceil_hit = 1'b0;
    if (addr_i == OFS_REG4_ACTIVE) begin
      hit[0] = 1'b1;
    end else if (addr_i == OFS_REG4_CEIL) begin
      ceil_hit = 1'b1;
    end else if (addr_i == OFS_REG5_CTRL) begin
      hit[1] = 1'b1;
    end else if (addr_i == OFS_REG6_CTRL) begin
      hit[2] = 1'b1;
    end else if (addr_i == OFS_REG7_CTRL) begin
      hit[3] = 1'b1;
    end else if (addr_i == OFS_REG8_CTRL) begin
      hit[4] = 1'b1;
    end else if (addr_i == OFS_REG9_CTRL) begin
      hit[5] = 1'b1;
    end
  end

  assign clamped = (wdata_i[5:0] > ceil) ? ceil : wdata_i[5:0];

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < NUM_LDO; g++) begin : g_ldo
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          ctrl[g] <= {OTP_CTRL_DEFAULT[g*8+7], LOWPWR_RST,
                      OTP_CTRL_DEFAULT[g*8+5 -: 6]};
        end else if (otp_reload_i) begin
          ctrl[g] <= {OTP_CTRL_DEFAULT[g*8+7], LOWPWR_RST,
                      OTP_CTRL_DEFAULT[g*8+5 -: 6]};
        end else if (wr_en_i && hit[g]) begin
          ctrl[g][BIT_ENABLE] <= wdata_i[BIT_ENABLE];
          ctrl[g][BIT_LOWPWR] <= wdata_i[BIT_LOWPWR];
          ctrl[g][5:0] <= (g == 0) ? clamped : wdata_i[5:0];
        end
      end
      assign ldo_en_o[g] = ctrl[g][BIT_ENABLE] & ~forced_off_i[g];
      assign ldo_lowpwr_o[g] = ctrl[g][BIT_LOWPWR];
      if (g < 2) begin : g_hi
        assign ldo_sel_o[g*SEL_W +: SEL_W] = {1'b1, ctrl[g][4:0]};
      end else begin : g_full
        assign ldo_sel_o[g*SEL_W +: SEL_W] = ctrl[g][5:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Ceiling register
  //
  // Only the two open codes leave the ceiling writable. Any other code
  // locks, whether it arrived by a write or came from the programmed
  // default; only a default reload or a power-on reset unlocks it.
  // The range bits of this ceiling live outside this bank.
  // open code test
  assign ceil_open = (ceil == CEIL_OPEN_HI) || (ceil == CEIL_OPEN_LO);

  // write gate
  // The sticky flag sets one cycle after a locking code is stored, so the
  // gate also looks at the stored code itself; otherwise a second write
  // on the very next cycle would slip past the lock.
  assign ceil_wr_ok = wr_en_i && ceil_hit && !ceil_lock && ceil_open;

  always_comb begin
    next_ceil = ceil;
    if (ceil_wr_ok) begin
      next_ceil = wdata_i[5:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ceil <= OTP_CEIL_DEFAULT;
    end else if (otp_reload_i) begin
      ceil <= OTP_CEIL_DEFAULT;
    end else begin
      ceil <= next_ceil;
    end
  end

  // sticky lock
  // A reload in the same cycle as a locking code wins: the default is
  // stored and the lock is judged again from it on the next cycle.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ceil_lock <= 1'b0;
    end else if (otp_reload_i) begin
      ceil_lock <= 1'b0;
    end else if (!ceil_open) begin
      ceil_lock <= 1'b1;
    end
  end

  assign ceil_locked_o = ceil_lock | ~ceil_open;

  ////////////////////////////////////////////////////////////////////////
  // Read path
  //
  // The mux is combinational and only its result is registered, so read
  // data appears the cycle after the strobe and then holds.
  // Unmapped offsets read zero with the hit flag low.
  always_comb begin
    next_rdata = '0;
    next_rd_hit = 1'b1;
    if (ceil_hit) begin
      next_rdata = {CEIL_RSVD_VAL, ceil};
    end else if (hit[0]) begin
      next_rdata = {ctrl[0][7:6], 1'b1, ctrl[0][4:0]};
    end else if (hit[1]) begin
      // Same forced bit for regulator five
      next_rdata = {ctrl[1][7:6], 1'b1, ctrl[1][4:0]};
    end else if (hit[2]) begin
      // Regulators six to nine read back unchanged
      next_rdata = ctrl[2];
    end else if (hit[3]) begin
      next_rdata = ctrl[3];
    end else if (hit[4]) begin
      next_rdata = ctrl[4];
    end else if (hit[5]) begin
      next_rdata = ctrl[5];
    end else begin
      next_rd_hit = 1'b0;
    end
  end

  // Read data holds until the next read, so a host may take it late
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= '0;
    end else if (rd_en_i) begin
      rdata_o <= next_rdata;
    end
  end

  // Hit flag is high only in the cycle after each strobe cycle that hits; it does not hold
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_hit_o <= 1'b0;
    end else begin
      rd_hit_o <= rd_en_i && next_rd_hit;
    end
  end

endmodule : ldoreg_bank
`default_nettype wire

// *** core/ldoreg_pkg.sv ***
package ldoreg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned NUM_REG = 7;
  // Register offsets
  localparam logic [7:0] OFS_REG4_ACTIVE = 8'h1a;
  localparam logic [7:0] OFS_REG4_CEIL = 8'h1b;
  localparam logic [7:0] OFS_REG5_CTRL = 8'h1c;
  localparam logic [7:0] OFS_REG6_CTRL = 8'h1d;
  localparam logic [7:0] OFS_REG7_CTRL = 8'h1e;
  localparam logic [7:0] OFS_REG8_CTRL = 8'h1f;
  localparam logic [7:0] OFS_REG9_CTRL = 8'h20;
  // Field positions
  localparam int unsigned BIT_ENABLE = 7;
  localparam int unsigned BIT_LOWPWR = 6;
  localparam int unsigned BIT_SEL_TOP = 5;
  // Fixed reset and reserved-bit values and ceiling codes that leave the ceiling unlocked
  localparam logic LOWPWR_RST = 1'h0;
  localparam logic [1:0] CEIL_RSVD_VAL = 2'h0;
  localparam logic [5:0] CEIL_OPEN_HI = 6'h3f;
  localparam logic [5:0] CEIL_OPEN_LO = 6'h00;
endpackage : ldoreg_pkg

// *** verification/ldoreg_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module ldoreg_props
  import ldoreg_pkg::*;
#(parameter int unsigned NUM_LDO = 6) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic otp_reload_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic rd_hit_o,
  input wire logic [NUM_LDO-1:0] forced_off_i,
  input wire logic [NUM_LDO-1:0] ldo_en_o,
  input wire logic [NUM_LDO*SEL_W-1:0] ldo_sel_o,
  input wire logic ceil_locked_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic hit;
  assign hit = addr_i inside {[8'h1a:8'h20]};
  read_hit_a: assert property (rd_en_i |=> rd_hit_o == $past(hit))
    else $error("read hit flag wrong");
  en_gate_a: assert property ((ldo_en_o & forced_off_i) == '0)
    else $error("forced-off regulator enabled");
  top_bit_a: assert property (ldo_sel_o[5] && ldo_sel_o[11])
    else $error("top select bit low");
  lock_hold_a: assert property (ceil_locked_o && !otp_reload_i |=>
    ceil_locked_o) else $error("lock dropped");
  lock_set_a: assert property (wr_en_i && addr_i == OFS_REG4_CEIL
    && !otp_reload_i && !(wdata_i[5:0] inside {6'h00, 6'h3f}) |=>
    ceil_locked_o) else $error("lock not set");
  ceil_clamp_a: assert property (wr_en_i && addr_i == OFS_REG4_ACTIVE
    && !otp_reload_i && !wdata_i[5] |=>
    ldo_sel_o[5:0] <= ($past(wdata_i[5:0]) | 6'h20))
    else $error("code above write");
  six_write_a: assert property (wr_en_i && addr_i == OFS_REG6_CTRL
    && !otp_reload_i |=> ldo_sel_o[17:12] == $past(wdata_i[5:0]) &&
    ldo_en_o[2] == ($past(wdata_i[7]) && !forced_off_i[2]))
    else $error("regulator six write lost");
  // Holds for the default programmed values only
  reload_def_a: assert property (otp_reload_i |=> !ceil_locked_o &&
    ldo_en_o == '0 && ldo_sel_o == 36'h000000820)
    else $error("defaults not reloaded");
endmodule : ldoreg_props
`default_nettype wire

// *** verification/tb_ldoreg_bank.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_ldoreg_bank
  import ldoreg_pkg::*;
();
  logic clk_i = 1'h0, arst_n_i = 1'h0, otp_reload_i = 1'h0;
  logic wr_en_i = 1'h0, rd_en_i = 1'h0, rd_hit_o, ceil_locked_o;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic [5:0] forced_off_i = 6'h00, ldo_en_o, ldo_lowpwr_o;
  logic [35:0] ldo_sel_o;
  int fails = 0, samples_checked = 0;
  ldoreg_bank uut (.*);
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    wr_en_i <= 1'h1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'h0;
  endtask : wr
  task automatic rc(input logic [7:0] a, e);
    @(posedge clk_i);
    rd_en_i <= 1'h1; addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'h0;
    #1 `CHK(rdata_o, e)
  endtask : rc
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'h1;
    rc(OFS_REG4_CEIL, 8'h3f);
    rc(OFS_REG4_ACTIVE, 8'h20);
    for (int i = 8'h1c; i <= 8'h20; i++) begin
      wr(i[7:0], 8'hc0 | i[7:0]);
      rc(i[7:0], (i == 8'h1c) ? 8'hfc : 8'hc0 | i[7:0]);
      `CHK(rd_hit_o, 1'h1)
    end
    `CHK(ldo_lowpwr_o, 6'h3e)
    @(posedge clk_i);
    forced_off_i <= 6'h0a;
    #1 `CHK(ldo_en_o, 6'h34)
    rc(8'h21, 8'h00);
    `CHK(rd_hit_o, 1'h0)
    wr(OFS_REG4_CEIL, 8'h28);
    #1 `CHK(ceil_locked_o, 1'h1)
    wr(OFS_REG4_ACTIVE, 8'hff);
    rc(OFS_REG4_ACTIVE, 8'he8);
    wr(OFS_REG4_ACTIVE, 8'h67);
    rc(OFS_REG4_ACTIVE, 8'h67);
    wr(OFS_REG4_ACTIVE, 8'h07);
    rc(OFS_REG4_ACTIVE, 8'h27);
    wr(OFS_REG4_CEIL, 8'h3f);
    rc(OFS_REG4_CEIL, 8'h28);
    @(posedge clk_i);
    arst_n_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'h1;
    rc(OFS_REG4_CEIL, 8'h3f);
    rc(OFS_REG9_CTRL, 8'h00);
    `CHK(ldo_lowpwr_o, 6'h00)
    wr(OFS_REG4_CEIL, 8'h28);
    @(posedge clk_i);
    otp_reload_i <= 1'h1;
    @(posedge clk_i);
    otp_reload_i <= 1'h0;
    rc(OFS_REG9_CTRL, 8'h00);
    rc(OFS_REG4_CEIL, 8'h3f);
    wr(OFS_REG4_CEIL, 8'h00);
    wr(OFS_REG4_CEIL, 8'h3f);
    rc(OFS_REG4_CEIL, 8'h3f);
    conclude();
  end
endmodule : tb_ldoreg_bank
bind ldoreg_bank ldoreg_props #(.NUM_LDO(NUM_LDO)) u_props (.*);
`default_nettype wire
